// File: rtl/sgm_pkg.sv
// Package: register map, field layout and command types of the stop guard and system mode block
package sgm_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] ADDR_SYSTEM_MODE_CONTROL = 8'hde;
    localparam logic [7:0] ADDR_STOP_ARM_GUARD      = 8'hf3;

    // ****************************************************************
    // Stop guard values
    // ****************************************************************
    localparam logic [7:0] STOP_KEY        = 8'ha5;  // 10100101
    localparam logic [7:0] STOP_GUARD_RST  = 8'h00;

    // ****************************************************************
    // System mode fields
    // ****************************************************************
    localparam int          SYM_TRI_BIT     = 7;
    localparam int          SYM_LVL_LSB     = 2;
    localparam int          SYM_FIE_BIT     = 1;
    localparam int          SYM_GIE_BIT     = 0;
    localparam logic [7:0]  SYM_WRITE_MASK  = 8'h9f;  // Bits 6 and 5 unused
    localparam logic [7:0]  SYM_RST         = 8'h00;
    localparam logic [2:0]  FAST_LVL_UNUSED = 3'h5;
    localparam logic [2:0]  FAST_LVL_RST    = 3'h0;

    // CPU register access carried as one bundle
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sgm_reg_req_t;

    // CPU instruction events that touch this block
    typedef struct packed {
        logic stop;      // Stop instruction executed
        logic int_en;    // Interrupt enable instruction
        logic int_dis;   // Interrupt disable instruction
    } sgm_cpu_evt_t;

endpackage : sgm_pkg

// File: rtl/sgm_stop_guard_sysmode.sv
// Module: stop guard and system mode control registers
`timescale 1ns/1ps
module sgm_stop_guard_sysmode
(
    input  wire logic                 clk,
    input  wire logic                 srst,
    input  wire sgm_pkg::sgm_reg_req_t reg_req,
    input  wire sgm_pkg::sgm_cpu_evt_t cpu_evt,
    output logic [7:0]                rdata,
    output logic                      stop_enter,
    output logic                      stop_reset_req,
    output logic                      ext_if_oe_n,
    output logic                      global_int_en,
    output logic                      fast_int_en,
    output logic [2:0]                fast_int_level,
    output logic                      fast_level_valid
);

    // ****************************************************************
    // Local sizes
    // ****************************************************************
    // The fast level field is three bits wide, matching its output port
    localparam int LVL_W = 3;

    // ****************************************************************
    // State and next values
    // ****************************************************************
    logic [7:0]       stop_arm_guard;           // Keyed stop guard register
    logic [7:0]       system_mode_control;      // System mode register
    logic [7:0]       next_stop_arm_guard;
    logic [7:0]       next_system_mode_control;
    logic [7:0]       next_rdata;
    logic             next_stop_enter;
    logic             next_stop_reset_req;
    logic             next_ext_if_oe_n;
    logic             next_global_int_en;
    logic             next_fast_int_en;
    logic [LVL_W-1:0] next_fast_int_level;
    logic             next_fast_level_valid;
    logic             guard_write;              // Write aimed at the guard this cycle
    logic             mode_write;               // Write aimed at the mode register

    // ****************************************************************
    // Decode helpers
    // ****************************************************************
    // True only for the exact key; every other byte keeps stop unavailable
    function automatic logic key_ok(input logic [7:0] v);
        key_ok = (v == sgm_pkg::STOP_KEY);
    endfunction : key_ok

    // Register strobe aimed at one address
    function automatic logic reg_hit(input logic       strobe,
                                     input logic [7:0] addr,
                                     input logic [7:0] target);
        reg_hit = strobe && (addr == target);
    endfunction : reg_hit

    // Fast level field of a mode value
    function automatic logic [LVL_W-1:0] fast_level(input logic [7:0] v);
        fast_level = v[sgm_pkg::SYM_LVL_LSB +: LVL_W];
    endfunction : fast_level

    // The unused level code never qualifies, so a stray code cannot win fast service
    function automatic logic fast_ok(input logic [7:0] v);
        fast_ok = v[sgm_pkg::SYM_FIE_BIT] && (fast_level(v) != sgm_pkg::FAST_LVL_UNUSED);
    endfunction : fast_ok

    // ****************************************************************
    // Strobe decode
    // ****************************************************************
    // Shared by the guard and mode groups; unmapped writes hit neither
    assign guard_write = reg_hit(reg_req.wr, reg_req.addr, sgm_pkg::ADDR_STOP_ARM_GUARD);
    assign mode_write  = reg_hit(reg_req.wr, reg_req.addr, sgm_pkg::ADDR_SYSTEM_MODE_CONTROL);

    // ****************************************************************
    // Stop guard group
    // ****************************************************************
    // A successful stop beats a guard write in the same cycle, so a consumed key never survives
    always_comb
    begin
        next_stop_arm_guard = stop_arm_guard;
        next_stop_enter     = 1'b0;
        next_stop_reset_req = 1'b0;
        if (guard_write)
        begin
            next_stop_arm_guard = reg_req.wdata;
        end
        if (cpu_evt.stop)
        begin
            if (key_ok(stop_arm_guard))
            begin
                next_stop_enter     = 1'b1;
                next_stop_arm_guard = sgm_pkg::STOP_GUARD_RST;
            end
            else
            begin
                // Only a request; the device reset comes back to us on srst
                next_stop_reset_req = 1'b1;
            end
        end
    end

    // A stop in the reset cycle is dropped along with everything else
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            stop_arm_guard <= sgm_pkg::STOP_GUARD_RST;
            stop_enter     <= 1'b0;
            stop_reset_req <= 1'b0;
        end
        else
        begin
            stop_arm_guard <= next_stop_arm_guard;
            stop_enter     <= next_stop_enter;
            stop_reset_req <= next_stop_reset_req;
        end
    end

    // ****************************************************************
    // System mode group
    // ****************************************************************
    // Instruction events beat a mode write on bit 0, and enable beats disable
    always_comb
    begin
        next_system_mode_control = system_mode_control;
        if (mode_write)
        begin
            next_system_mode_control = reg_req.wdata & sgm_pkg::SYM_WRITE_MASK;
        end
        if (cpu_evt.int_en)
        begin
            next_system_mode_control[sgm_pkg::SYM_GIE_BIT] = 1'b1;
        end
        else if (cpu_evt.int_dis)
        begin
            next_system_mode_control[sgm_pkg::SYM_GIE_BIT] = 1'b0;
        end
        // Outputs follow the new value so they move on the same edge as the register
        next_ext_if_oe_n      = next_system_mode_control[sgm_pkg::SYM_TRI_BIT];
        next_global_int_en    = next_system_mode_control[sgm_pkg::SYM_GIE_BIT];
        next_fast_int_en      = next_system_mode_control[sgm_pkg::SYM_FIE_BIT];
        next_fast_int_level   = fast_level(next_system_mode_control);
        next_fast_level_valid = fast_ok(next_system_mode_control);
    end

    // Active low enable: high floats the lines; level bits reset to a known code
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            system_mode_control <= sgm_pkg::SYM_RST;
            ext_if_oe_n         <= sgm_pkg::SYM_RST[sgm_pkg::SYM_TRI_BIT];
            global_int_en       <= sgm_pkg::SYM_RST[sgm_pkg::SYM_GIE_BIT];
            fast_int_en         <= sgm_pkg::SYM_RST[sgm_pkg::SYM_FIE_BIT];
            fast_int_level      <= sgm_pkg::FAST_LVL_RST;
            fast_level_valid    <= 1'b0;
        end
        else
        begin
            system_mode_control <= next_system_mode_control;
            ext_if_oe_n         <= next_ext_if_oe_n;
            global_int_en       <= next_global_int_en;
            fast_int_en         <= next_fast_int_en;
            fast_int_level      <= next_fast_int_level;
            fast_level_valid    <= next_fast_level_valid;
        end
    end

    // ****************************************************************
    // Read group
    // ****************************************************************
    // Unmapped reads return zero; a read never disturbs either register
    always_comb
    begin
        next_rdata = '0;
        if (reg_req.rd)
        begin
            unique case (reg_req.addr)
                sgm_pkg::ADDR_STOP_ARM_GUARD:      next_rdata = stop_arm_guard;
                sgm_pkg::ADDR_SYSTEM_MODE_CONTROL: next_rdata = system_mode_control;
                default:                           next_rdata = '0;
            endcase
        end
    end

    // Read data stands for one cycle, then falls back to zero
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rdata <= '0;
        end
        else
        begin
            rdata <= next_rdata;
        end
    end

endmodule : sgm_stop_guard_sysmode

// File: tb/sgm_properties.sv
// Checker: port-level properties of the stop guard and system mode block
`timescale 1ns/1ps
module sgm_chk
(
    input wire logic                  clk,
    input wire logic                  srst,
    input wire sgm_pkg::sgm_reg_req_t reg_req,
    input wire sgm_pkg::sgm_cpu_evt_t cpu_evt,
    input wire logic [7:0]            rdata,
    input wire logic                  stop_enter,
    input wire logic                  stop_reset_req,
    input wire logic                  ext_if_oe_n,
    input wire logic                  global_int_en,
    input wire logic                  fast_int_en,
    input wire logic [2:0]            fast_int_level,
    input wire logic                  fast_level_valid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // Stop outcomes, then mode writes carrying the fields to the control outputs, with instruction events winning on the enable
    a_stop_outcome: assert property (cpu_evt.stop |=> stop_enter ^ stop_reset_req) else $error("stop lost");
    a_no_spurious: assert property (!cpu_evt.stop |=> !stop_enter && !stop_reset_req) else $error("stray stop");
    a_guard_rearm: assert property (stop_enter && cpu_evt.stop |=> stop_reset_req) else $error("guard kept");
    a_tri_follow: assert property (reg_req.wr && reg_req.addr == sgm_pkg::ADDR_SYSTEM_MODE_CONTROL
        |=> ext_if_oe_n == $past(reg_req.wdata[sgm_pkg::SYM_TRI_BIT])) else $error("tri bit");
    a_gie_write: assert property (reg_req.wr && reg_req.addr == sgm_pkg::ADDR_SYSTEM_MODE_CONTROL
        && !cpu_evt.int_en && !cpu_evt.int_dis
        |=> global_int_en == $past(reg_req.wdata[sgm_pkg::SYM_GIE_BIT])) else $error("gie write");
    a_gie_instr: assert property (cpu_evt.int_en |=> global_int_en) else $error("gie set");
    a_gie_off: assert property (cpu_evt.int_dis && !cpu_evt.int_en |=> !global_int_en) else $error("gie clear");
    a_fast_sel: assert property (reg_req.wr && reg_req.addr == sgm_pkg::ADDR_SYSTEM_MODE_CONTROL
        |=> {fast_int_level, fast_int_en} == $past(reg_req.wdata[4:1])) else $error("fast sel");
    a_fast_valid: assert property (fast_level_valid
        == (fast_int_en && fast_int_level != sgm_pkg::FAST_LVL_UNUSED)) else $error("fast valid");
endmodule : sgm_chk

// File: tb/sgm_stop_guard_sysmode_tb.sv
// Testbench: random register and instruction traffic against a cycle model
`timescale 1ns/1ps
module sgm_stop_guard_sysmode_tb;
    logic                  clk = 1'b0;
    logic                  srst = 1'b1;
    sgm_pkg::sgm_reg_req_t req = '0;
    sgm_pkg::sgm_cpu_evt_t evt = '0;
    logic [7:0]            rdata, erd = 8'h00, g = 8'h00, m = 8'h00;
    logic                  se, sr, oe_n, gie, fie, flv;
    logic [2:0]            lvl;
    logic [1:0]            es;
    logic [8:0]            ef = 9'h000;
    logic [31:0]           r;
    int                    failures = 0, checks = 0, seed = 14562, k;
    sgm_stop_guard_sysmode uut (.clk(clk), .srst(srst), .reg_req(req), .cpu_evt(evt),
        .rdata(rdata), .stop_enter(se), .stop_reset_req(sr), .ext_if_oe_n(oe_n),
        .global_int_en(gie), .fast_int_en(fie), .fast_int_level(lvl), .fast_level_valid(flv));
    task automatic cmp_data(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED %0t rdata %h want %h", $time, got, exp);
        end
    endtask : cmp_data
    task automatic cmp_flags(input logic [8:0] got, input logic [8:0] exp);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED %0t flags %h want %h", $time, got, exp);
        end
    endtask : cmp_flags
    task automatic close_out;
        $display("failures %0d checks %0d", failures, checks);
        if (failures == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : close_out
    // Free-running 200 MHz clock
    initial forever #2.5 clk = ~clk;
    // Hang guard, well past the 3000 cycle run
    initial
    begin
        #40000;
        failures++;
        close_out();
    end
    // Compare last cycle, then drive and model the next one; rd kept apart from writes
    initial
    begin
        repeat (12) @(posedge clk);
        repeat (3000)
        begin
            @(negedge clk);
            cmp_data(rdata, erd);
            cmp_flags({se, sr, oe_n, gie, fie, lvl, flv}, ef);
            k = $unsigned($random(seed)) % 6;
            r = $random(seed);
            srst = ($unsigned($random(seed)) % 97) == 0;
            req.wr = k < 2;
            req.rd = k == 2;
            evt.stop = k == 3;
            evt.int_en = k == 4 && r[8];
            evt.int_dis = k == 4 && r[9];
            req.addr = r[1] ? (r[0] ? sgm_pkg::ADDR_SYSTEM_MODE_CONTROL
                                    : sgm_pkg::ADDR_STOP_ARM_GUARD) : r[17:10];
            req.wdata = r[2] ? sgm_pkg::STOP_KEY : r[25:18];
            // Mode writes keep the enable as it is and the tri bit low but for a rare probe
            if (req.addr == sgm_pkg::ADDR_SYSTEM_MODE_CONTROL)
            begin
                req.wdata[0] = m[0];
                req.wdata[7] = &r[31:29];
            end
            es = {evt.stop && g == sgm_pkg::STOP_KEY, evt.stop && g != sgm_pkg::STOP_KEY};
            erd = !req.rd ? 8'h00 : req.addr == sgm_pkg::ADDR_SYSTEM_MODE_CONTROL ? m
                : req.addr == sgm_pkg::ADDR_STOP_ARM_GUARD ? g : 8'h00;
            if (req.wr && req.addr == sgm_pkg::ADDR_STOP_ARM_GUARD) g = req.wdata;
            if (es[1]) g = sgm_pkg::STOP_GUARD_RST;
            if (req.wr && req.addr == sgm_pkg::ADDR_SYSTEM_MODE_CONTROL)
                m = req.wdata & sgm_pkg::SYM_WRITE_MASK;
            if (evt.int_en) m[0] = 1'b1;
            else if (evt.int_dis) m[0] = 1'b0;
            if (srst)
                {g, m, erd, es} = '0;
            ef = {es, m[7], m[0], m[1], m[4:2], m[1] && m[4:2] != sgm_pkg::FAST_LVL_UNUSED};
        end
        close_out();
    end
endmodule : sgm_stop_guard_sysmode_tb
bind sgm_stop_guard_sysmode sgm_chk u_chk (.clk(clk), .srst(srst), .reg_req(reg_req),
    .cpu_evt(cpu_evt), .rdata(rdata), .stop_enter(stop_enter), .stop_reset_req(stop_reset_req),
    .ext_if_oe_n(ext_if_oe_n), .global_int_en(global_int_en), .fast_int_en(fast_int_en),
    .fast_int_level(fast_int_level), .fast_level_valid(fast_level_valid));
